// ==== design/dbc_pkg.sv ====
package dbc_pkg;
    // command pin levels {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_LMR = 3'h0;
    // geometry
    localparam int NUM_BANKS = 4;
    localparam int BA_W = 2;
    localparam int ADDR_W = 14;
    localparam int COL_W = 10;
    localparam int AP_BIT = 10;
    // timing defaults, cycles of 4 ns
    localparam int CK_PS = 4000;
    localparam int T_WTR_PS = 7500;
    localparam int T_RCD_PS = 15000;
    localparam int T_RP_PS = 15000;
    localparam int T_RFC_PS = 105000;
    localparam int T_MRD_CK = 2;
    localparam int WTR_MIN_CK = 2;
    localparam int AP_TO_ACT_CK = 1;
    localparam int RD_WR_GAP_CK = 2;
    localparam int CNT_W = 8;
    // least times round up
    localparam int WTR_RAW = (T_WTR_PS + CK_PS - 1) / CK_PS;
    localparam int WTR_CK = (WTR_RAW > WTR_MIN_CK) ? WTR_RAW : WTR_MIN_CK;
    localparam int RCD_CK = (T_RCD_PS + CK_PS - 1) / CK_PS;
    localparam int RP_CK = (T_RP_PS + CK_PS - 1) / CK_PS;
    localparam int RFC_CK = (T_RFC_PS + CK_PS - 1) / CK_PS;
    localparam int CL_DEF = 5;
    localparam int BL_DEF = 4;
    localparam int AL_DEF = 0;

    // user request
    typedef struct packed {
        logic [2:0] op;
        logic [BA_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } dbc_req_s;

    // pin bundle toward the memory
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] a;
    } dbc_pins_s;

    // per-bank state
    typedef enum logic [1:0] {
        BK_IDLE, BK_OPENING, BK_OPEN, BK_CLOSING
    } dbc_bank_e;
endpackage

// ==== design/dbc_ctrl.sv ====
// Contract
// - nop is cs low, others high
// - issue only with clock enable held high
// - other bank may be commanded while busy
// - idle bank n imposes nothing on m
// - act/pre/read/write encodings to other bank
// - write after read burst completes
// - write-to-read waits max of two, tWTR
// - refresh and mode load only all idle
// - no read and write data contention
// - auto precharge cross-bank minimum delays
// - no command until mode set delay
// - precharge before activating another row
// - additive latency allows early column
// - never emit illegal state and command
`timescale 1ns/1ns
module dbc_ctrl
    import dbc_pkg::*;
#(
    parameter int CL = CL_DEF,
    parameter int BL = BL_DEF,
    parameter int AL = AL_DEF
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // user request
    input wire logic req_valid_in,
    input wire dbc_req_s req_in,
    output logic req_ready_out,
    output logic req_reject_out,
    // memory pins
    output dbc_pins_s pins_out,
    // status
    output logic [NUM_BANKS-1:0] bank_open_out
);
    // derived delays
    localparam int BL2 = BL / 2;
    localparam int RD2WR = BL2 + RD_WR_GAP_CK;
    localparam int WR2RD = (CL - 1) + BL2 + WTR_CK;
    localparam int RD2PRE = AL + BL2;
    localparam int WR2PRE = AL + CL - 1 + BL2 + WTR_CK;
    localparam logic [CNT_W-1:0] C_ONE = CNT_W'(1);

    // per-bank state and timers
    dbc_bank_e bst_q [NUM_BANKS];
    logic [CNT_W-1:0] btm_q [NUM_BANKS];
    logic [ADDR_W-1:0] row_q [NUM_BANKS];
    logic [NUM_BANKS-1:0] ap_q;
    // global spacing timers
    logic [CNT_W-1:0] rd_gap_q, wr_gap_q, any_gap_q;
    logic cke_q;
    dbc_pins_s pins_q;
    logic ready_q, reject_q;

    // decode of the request
    wire is_act = req_in.op == CMD_ACT;
    wire is_rd = req_in.op == CMD_RD;
    wire is_wr = req_in.op == CMD_WR;
    wire is_pre = req_in.op == CMD_PRE;
    wire is_ref = req_in.op == CMD_REF;
    wire is_lmr = req_in.op == CMD_LMR;
    wire is_nop = req_in.op == CMD_NOP;
    wire is_col = is_rd | is_wr;
    // the addressed bank's own state gates activate, column and precharge requests
    wire dbc_bank_e cur_st = bst_q[req_in.bank];
    wire cur_tm0 = btm_q[req_in.bank] == '0;

    // all banks idle with no pending timer
    logic all_idle;
    always_comb begin
        all_idle = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (bst_q[i] != BK_IDLE || btm_q[i] != '0) begin
                all_idle = 1'b0;
            end
        end
    end

    // legality of the request against bank and spacing state
    wire gap_ok = any_gap_q == '0;
    wire act_ok = cur_st == BK_IDLE && cur_tm0;
    // early column allowed by additive latency
    wire col_st_ok = (cur_st == BK_OPEN && !ap_q[req_in.bank]) ||
                     (cur_st == BK_OPENING &&
                      btm_q[req_in.bank] <= CNT_W'(AL));
    wire rd_ok = col_st_ok && rd_gap_q == '0;
    wire wr_ok = col_st_ok && wr_gap_q == '0;
    wire pre_ok = (cur_st == BK_OPEN && cur_tm0 && !ap_q[req_in.bank]) ||
                  cur_st == BK_IDLE;
    wire legal = cke_q && gap_ok && (is_nop ||
                 (is_act && act_ok) || (is_rd && rd_ok) ||
                 (is_wr && wr_ok) || (is_pre && pre_ok) ||
                 ((is_ref || is_lmr) && all_idle));
    wire take = req_valid_in && legal && ready_q;
    wire refuse = req_valid_in && !legal;
    wire ap_bit = req_in.addr[AP_BIT];

    // pin values for the taken command
    dbc_pins_s pins_d;
    always_comb begin
        pins_d = pins_q;
        pins_d.cke = 1'b1;
        pins_d.cs_n = 1'b1; // deselect by default
        if (take) begin
            pins_d.cs_n = 1'b0;
            {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = req_in.op;
            pins_d.ba = req_in.bank;
            pins_d.a = req_in.addr;
            if (is_col) begin
                // column bits plus the auto precharge flag
                pins_d.a = '0;
                pins_d.a[COL_W-1:0] = req_in.addr[COL_W-1:0];
                pins_d.a[AP_BIT] = ap_bit;
            end
        end
    end

    // clock enable held high after reset
    always_ff @(posedge mclk_in) begin
        cke_q <= !srst_in;
    end

    // output registers
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pins_q <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                        we_n: 1'b1, ba: '0, a: '0};
            ready_q <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            pins_q <= pins_d;
            ready_q <= 1'b1;
            reject_q <= refuse;
        end
    end

    // global spacing counters
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rd_gap_q <= '0;
            wr_gap_q <= '0;
            any_gap_q <= '0;
        end else if (take && is_lmr) begin
            any_gap_q <= CNT_W'(T_MRD_CK - 1);
        end else if (take && is_ref) begin
            any_gap_q <= CNT_W'(RFC_CK - 1);
        end else begin
            if (any_gap_q != '0) begin
                any_gap_q <= any_gap_q - C_ONE;
            end
            if (take && is_rd) begin
                // read burst must drain before a write
                rd_gap_q <= CNT_W'(BL2 - 1);
                wr_gap_q <= CNT_W'(RD2WR - 1);
            end else if (take && is_wr) begin
                // write-to-read turnaround
                rd_gap_q <= CNT_W'(WR2RD - 1);
                wr_gap_q <= CNT_W'(BL2 - 1);
            end else begin
                if (rd_gap_q != '0) begin
                    rd_gap_q <= rd_gap_q - C_ONE;
                end
                if (wr_gap_q != '0) begin
                    wr_gap_q <= wr_gap_q - C_ONE;
                end
            end
        end
    end

    // per-bank state machines
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        wire hit = take && req_in.bank == BA_W'(b);
        always_ff @(posedge mclk_in) begin
            if (srst_in) begin
                bst_q[b] <= BK_IDLE;
                btm_q[b] <= '0;
                row_q[b] <= '0;
                ap_q[b] <= 1'b0;
            end else if (hit && is_act) begin
                bst_q[b] <= BK_OPENING;
                btm_q[b] <= CNT_W'(RCD_CK - 1);
                row_q[b] <= req_in.addr;
            end else if (hit && is_col) begin
                bst_q[b] <= BK_OPEN;
                ap_q[b] <= ap_bit;
                // access period before the bank may close
                btm_q[b] <= is_rd ? CNT_W'(RD2PRE) : CNT_W'(WR2PRE);
            end else if (hit && is_pre) begin
                bst_q[b] <= BK_CLOSING;
                btm_q[b] <= CNT_W'(RP_CK - 1);
            end else if (btm_q[b] != '0) begin
                btm_q[b] <= btm_q[b] - C_ONE;
            end else begin
                unique case (bst_q[b])
                    BK_OPENING: bst_q[b] <= BK_OPEN;
                    BK_OPEN: begin
                        if (ap_q[b]) begin
                            // auto precharge period begins
                            bst_q[b] <= BK_CLOSING;
                            btm_q[b] <= CNT_W'(RP_CK - 1);
                            ap_q[b] <= 1'b0;
                        end
                    end
                    BK_CLOSING: bst_q[b] <= BK_IDLE;
                    BK_IDLE: ;
                endcase
            end
        end
    end

    // bank open flags registered
    logic [NUM_BANKS-1:0] open_q;
    always_ff @(posedge mclk_in) begin
        for (int i = 0; i < NUM_BANKS; i++) begin
            open_q[i] <= srst_in ? 1'b0 : bst_q[i] != BK_IDLE;
        end
    end

    assign pins_out = pins_q;
    assign req_ready_out = ready_q;
    assign req_reject_out = reject_q;
    assign bank_open_out = open_q;

    // checks on commands leaving the block
    a_lmr_all_idle: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && (is_lmr || is_ref) |-> all_idle)
        else $error("refresh or mode load with bank busy");
    a_mrd_quiet: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && is_lmr |=> !take)
        else $error("command inside mode set delay");
    // refresh holds off every command for a while
    a_rfc_quiet: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && is_ref |=> (!take) [*8])
        else $error("command inside refresh time");
    // turnaround and same-direction spacing between column commands
    a_rd_wr_gap: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && is_rd |=> !(take && is_wr))
        else $error("write too soon after read");
    a_wr_rd_gap: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && is_wr |=> !(take && is_rd) [*2])
        else $error("read too soon after write");
    a_rd_rd_gap: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && is_rd |=> !(take && is_rd))
        else $error("read too soon after read");
    a_wr_wr_gap: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && is_wr |=> !(take && is_wr))
        else $error("write too soon after write");
    // bank state gating
    a_act_closed: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && is_act |-> cur_st == BK_IDLE)
        else $error("activate on open bank");
    a_col_open: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && is_col |-> cur_st == BK_OPEN || cur_st == BK_OPENING)
        else $error("column command to closed bank");
    a_pre_no_ap: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && is_pre |-> !(cur_st == BK_OPEN && ap_q[req_in.bank]))
        else $error("precharge during auto precharge access");
    // what the pins show around a take
    a_cke_held: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take |-> pins_out.cke)
        else $error("command issued with clock enable low");
    a_cmd_pins: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take |=> !pins_out.cs_n && pins_out.ba == $past(req_in.bank))
        else $error("taken command not driven");
    a_row_kept: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && is_act |=> pins_out.a == row_q[$past(req_in.bank)])
        else $error("stored row differs from driven row");
    a_idle_desel: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        !take |=> pins_out.cs_n)
        else $error("chip select low without command");
    a_ap_flag: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        take && is_col |=> pins_out.a[AP_BIT] == $past(ap_bit))
        else $error("auto precharge bit lost");
    // refusal answer
    a_reject_pulse: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        refuse |=> req_reject_out)
        else $error("illegal request not refused");
endmodule

// ==== bench/dbc_mem_model.sv ====
`timescale 1ns/1ns
module dbc_mem_model
    import dbc_pkg::*;
(
    // clock
    input wire logic mclk_in,
    // command pins from the controller
    input wire dbc_pins_s pins_in,
    // observations for the bench
    output logic [7:0] viol_out,
    output logic [ADDR_W-1:0] mode_out,
    output logic [BA_W-1:0] mode_sel_out
);
    logic [NUM_BANKS-1:0] open_q; // banks with a row held open
    logic [2:0] cmd; // decoded command levels
    logic cke_q; // clock enable seen at the previous edge
    assign cmd = {pins_in.ras_n, pins_in.cas_n, pins_in.we_n};
    initial begin
        viol_out = 8'h00;
        open_q = '0;
        cke_q = 1'b0;
        mode_out = '0;
        mode_sel_out = '0;
    end
    // act on a command only while selected with clock enable high
    always @(posedge mclk_in) begin
        cke_q <= pins_in.cke;
        if (pins_in.cke && !pins_in.cs_n) begin
            // clock enable must have been high one edge earlier too
            if (!cke_q) viol_out <= viol_out + 8'h01;
            case (cmd)
                CMD_ACT: begin
                    if (open_q[pins_in.ba]) viol_out <= viol_out + 8'h01;
                    open_q[pins_in.ba] <= 1'b1;
                end
                CMD_RD, CMD_WR: begin
                    if (!open_q[pins_in.ba]) viol_out <= viol_out + 8'h01;
                    if (pins_in.a[AP_BIT]) open_q[pins_in.ba] <= 1'b0;
                end
                // row closes, bank goes idle
                CMD_PRE: open_q[pins_in.ba] <= 1'b0;
                CMD_LMR, CMD_REF: begin
                    if (open_q != '0) viol_out <= viol_out + 8'h01;
                    if (cmd == CMD_LMR) mode_out <= pins_in.a;
                    if (cmd == CMD_LMR) mode_sel_out <= pins_in.ba;
                end
                default: ; // nop leaves state alone
            endcase
        end
    end
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top
    import dbc_pkg::*;
;
    // expected outcome of one request
    typedef struct packed {
        logic ok;
        logic [2:0] op;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] a;
    } dbc_note_s;
    logic mclk_in, srst_in, req_valid, ready, reject;
    dbc_req_s req;
    dbc_pins_s pins;
    logic [NUM_BANKS-1:0] bank_open;
    logic [7:0] viol;
    logic [ADDR_W-1:0] mode, row;
    logic [BA_W-1:0] mode_sel;
    logic [COL_W-1:0] col;
    dbc_note_s notes[$], nt; // pending expectations
    int checks = 0, n_mismatch = 0, cyc = 0, seed = 36;
    dbc_ctrl dbc_ctrl_i (.mclk_in(mclk_in), .srst_in(srst_in),
        .req_valid_in(req_valid), .req_in(req), .req_ready_out(ready),
        .req_reject_out(reject), .pins_out(pins), .bank_open_out(bank_open));
    dbc_mem_model dbc_mem_model_i (.mclk_in(mclk_in), .pins_in(pins),
        .viol_out(viol), .mode_out(mode), .mode_sel_out(mode_sel));
    // 250 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    // verdict and end of run
    task automatic stop_test();
        $display("counts: checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // value comparison
    task automatic cmp_val(input logic [19:0] got, exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one request: take edge, then release
    task automatic issue(input logic [2:0] op, input logic [BA_W-1:0] ba,
        input logic [ADDR_W-1:0] a, input logic ok);
        logic [ADDR_W-1:0] pa;
        pa = a;
        if (op == CMD_RD || op == CMD_WR) pa = {3'h0, a[AP_BIT:0]};
        notes.push_back('{ok, op, ba, pa});
        req_valid <= 1'b1;
        req <= '{op, ba, a};
        @(posedge mclk_in);
        req_valid <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    // takes the oldest note whenever a command or refusal shows
    always @(negedge mclk_in) begin
        if (pins.cs_n === 1'b0 || reject === 1'b1) begin
            if (notes.size() == 0) begin
                cmp_val(20'h1, 20'h0, "unexpected output");
            end else begin
                nt = notes.pop_front();
                cmp_val({19'h0, reject}, {19'h0, !nt.ok}, "refusal");
                if (nt.ok && nt.op == CMD_NOP) cmp_val(
                    20'({pins.cke, pins.ras_n, pins.cas_n, pins.we_n}),
                    20'({1'b1, nt.op}), "nop");
                else if (nt.ok) cmp_val(20'({pins.ras_n, pins.cas_n,
                    pins.we_n, pins.ba, pins.a}), 20'({nt.op, nt.ba, nt.a}),
                    "pins");
            end
        end
    end
    // hang guard
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        srst_in = 1'b1;
        req_valid = 1'b0;
        req = '0;
        repeat (3) @(posedge mclk_in);
        #1 cmp_val(20'({pins.cke, pins.cs_n, ready}), 20'h2, "reset");
        @(posedge mclk_in);
        srst_in <= 1'b0;
        idle(3);
        row = 14'($random(seed));
        col = 10'($random(seed));
        issue(CMD_NOP, 2'h0, 14'h0, 1'b1);
        issue(CMD_RD, 2'h2, row, 1'b0);
        issue(CMD_ACT, 2'h0, row, 1'b1);
        issue(CMD_ACT, 2'h1, ~row, 1'b1);
        issue(CMD_LMR, 2'h0, row, 1'b0);
        idle(RCD_CK);
        @(negedge mclk_in);
        cmp_val(20'(bank_open), 20'h3, "open banks");
        @(posedge mclk_in);
        issue(CMD_ACT, 2'h0, row, 1'b0);
        issue(CMD_RD, 2'h0, {3'h0, 1'b1, col}, 1'b1);
        issue(CMD_RD, 2'h1, {4'h0, col}, 1'b1);
        issue(CMD_WR, 2'h1, 14'h0, 1'b0);
        idle(RD_WR_GAP_CK);
        issue(CMD_WR, 2'h1, 14'h0, 1'b1);
        issue(CMD_RD, 2'h1, 14'h0, 1'b0);
        idle(8);
        issue(CMD_RD, 2'h1, 14'h0, 1'b1);
        $display("test bank traffic done");
        idle(10);
        issue(CMD_PRE, 2'h1, 14'h0, 1'b1);
        idle(RP_CK + 20);
        @(negedge mclk_in);
        cmp_val(20'(bank_open), 20'h0, "idle banks");
        @(posedge mclk_in);
        issue(CMD_LMR, 2'h2, ~row, 1'b1);
        issue(CMD_NOP, 2'h0, 14'h0, 1'b1);
        issue(CMD_REF, 2'h0, 14'h0, 1'b1);
        issue(CMD_ACT, 2'h0, row, 1'b0);
        idle(4);
        @(negedge mclk_in);
        cmp_val({4'h0, mode_sel, mode}, {4'h0, 2'h2, ~row}, "mode");
        cmp_val(20'(viol), 20'h0, "device view");
        cmp_val(20'(notes.size()), 20'h0, "notes left");
        $display("test mode load done");
        stop_test();
    end
endmodule
